// ===== design/lrso_chan.sv
// One channel of the receive output formatter: pin roles, retiming, polarity.
`timescale 1ns/1ns
module lrso_chan
   import lrso_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  lrso_cfg_t cfg,
   input  lrso_line_t line,
   output lrso_pins_t pins
);

   logic       rclk_prev;
   logic       act_edge;
   logic       pos_raw;
   logic       neg_raw;
   logic       ind_raw;
   logic       rz_phase;
   logic       dat_h;
   logic       pos_h;
   logic       neg_h;
   logic       ind_h;
   lrso_pins_t next_pins;

   // ************************************************************
   // Edge select and rail slicing
   // ************************************************************
   assign act_edge = cfg.edge_fall ? (rclk_prev & ~line.rclk)
                                   : (~rclk_prev & line.rclk);
   assign pos_raw  = cfg.single_ended ? line.tip_hi
                                      : (line.tip_hi & line.ring_lo);
   assign neg_raw  = cfg.single_ended ? line.tip_lo
                                      : (line.tip_lo & line.ring_hi);
   // The pulse occupies the half period that follows the update edge.
   assign rz_phase = (line.rclk == ~cfg.edge_fall);

   always_comb
   begin
      case (cfg.ind_sel)
         LRSO_IND_PATT_SYNC: ind_raw = line.patt_sync;
         LRSO_IND_AIS:       ind_raw = line.ais;
         LRSO_IND_EXZ:       ind_raw = line.exz;
         LRSO_IND_BPV:       ind_raw = line.bpv;
         LRSO_IND_EXZ_BPV:   ind_raw = line.exz | line.bpv;
         LRSO_IND_LOS:       ind_raw = line.los;
         LRSO_IND_RCLK:      ind_raw = line.rclk;
         LRSO_IND_RAIL_XOR:  ind_raw = pos_raw ^ neg_raw;
         default:            ind_raw = 1'b0;
      endcase
   end

   // ************************************************************
   // Retiming on the active recovered edge
   // ************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rclk_prev <= 1'b0;
      else
         rclk_prev <= line.rclk;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dat_h <= 1'b0;
         pos_h <= 1'b0;
         neg_h <= 1'b0;
         ind_h <= 1'b0;
      end
      else if (act_edge)
      begin
         dat_h <= line.dec_data;
         pos_h <= pos_raw;
         neg_h <= neg_raw;
         ind_h <= ind_raw;
      end
   end

   // ************************************************************
   // Pin roles per format
   // ************************************************************
   always_comb
   begin
      next_pins = '0;
      case (cfg.fmt)
         LRSO_FMT_SINGLE_NRZ:
         begin
            next_pins.d1 = dat_h ^ cfg.data_pol;
            // A clock selection goes out as a clock, not a sample of it.
            next_pins.d2 = (cfg.ind_sel == LRSO_IND_RCLK) ? line.rclk : ind_h;
         end
         LRSO_FMT_DUAL_NRZ:
         begin
            next_pins.d1 = pos_h ^ cfg.data_pol;
            next_pins.d2 = neg_h ^ cfg.data_pol;
         end
         LRSO_FMT_DUAL_RZ:
         begin
            next_pins.d1 = (pos_h & rz_phase) ^ cfg.data_pol;
            next_pins.d2 = (neg_h & rz_phase) ^ cfg.data_pol;
         end
         LRSO_FMT_SLICED:
         begin
            next_pins.d1 = pos_raw ^ cfg.data_pol;
            next_pins.d2 = neg_raw ^ cfg.data_pol;
         end
         default:
         begin
            next_pins.d1 = 1'b0;
            next_pins.d2 = 1'b0;
         end
      endcase
      next_pins.d1_oe = 1'b1;
      next_pins.d2_oe = 1'b1;
      if (cfg.powerdown)
      begin
         next_pins.d1    = 1'b0;
         next_pins.d2    = 1'b0;
         next_pins.d1_oe = ~cfg.pd_tristate;
         next_pins.d2_oe = ~cfg.pd_tristate;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pins <= '0;
      else
         pins <= next_pins;
   end

endmodule // lrso_chan

// ===== design/lrso_top.sv
// Top of the 16-channel receive system-side output formatter with its register slave.
//
// Function
// - Single-rail NRZ puts the single data output on the first shared pin.
// - Single-rail NRZ outputs decoded data, changing on the selected recovered edge.
// - Polarity bit 3 sets the single data output active high or low.
// - Powered-down receiver makes single data output high impedance or low, bit 6.
// - Dual-rail formats use the first shared pin as positive rail output.
// - Dual-rail formats use the second shared pin as negative rail output.
// - Dual-rail NRZ shows undecoded rails as levels, updated on the active edge.
// - Dual-rail RZ shows undecoded rails as pulses, updated on the active edge.
// - Sliced format passes raw sliced rails through without recovered-clock retiming.
// - Differential input: positive rail for tip positive and ring negative.
// - Single-ended input: positive rail for positive tip, negative for negative tip.
// - Polarity bit 3 also sets the active level of both rail outputs.
// - Powered-down receiver makes both rails high impedance or low, bit 6.
// - Single-rail NRZ uses the second shared pin as indication output.
// - Field bits 7 to 5 select one of eight indication sources.
// - Indication changes on the active edge (the recovered clock source passes as a clock) and is always active high.
// - Powered-down receiver makes indication high impedance or low, bit 6.
// - Recovered clock runs at 1.544 MHz for T1/J1, 2.048 MHz for E1.
// - Bit 4 selects the recovered clock edge on which outputs change.
`timescale 1ns/1ns
module lrso_top
   import lrso_pkg::*;
(
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic [2:0]         s_axi_awprot,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [ADDR_W-1:0]  s_axi_araddr,
   input  wire logic [2:0]         s_axi_arprot,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  lrso_line_t [NUM_CH-1:0] line_in,
   output lrso_pins_t [NUM_CH-1:0] rx_pins,
   output logic [NUM_CH-1:0]       rx_clock_rate_ok
);

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [7:0]        cfg_a [NUM_CH];
   logic [7:0]        cfg_b [NUM_CH];
   lrso_cfg_t         ch_cfg [NUM_CH];

   logic              aw_full;
   logic              w_full;
   logic [ADDR_W-1:0] aw_addr;
   logic [7:0]        w_byte;
   logic              w_lane0;
   logic              do_write;
   logic              next_aw_full;
   logic              next_w_full;
   logic              next_rvalid;
   logic              ar_take;
   logic              wr_hit_a;
   logic              wr_hit_b;
   logic              wr_hit_st;
   logic [3:0]        wr_idx;
   logic [31:0]       rd_word;
   logic              rd_hit;

   // ************************************************************
   // Write address and data capture
   // ************************************************************
   // Address and data are held separately so they may arrive in either
   // order; the write itself waits until both are present and the
   // previous response has been accepted.
   assign do_write = aw_full & w_full & ~s_axi_bvalid;

   always_comb
   begin
      next_aw_full = aw_full;
      if (s_axi_awvalid && s_axi_awready)
         next_aw_full = 1'b1;
      else if (do_write)
         next_aw_full = 1'b0;
   end

   always_comb
   begin
      next_w_full = w_full;
      if (s_axi_wvalid && s_axi_wready)
         next_w_full = 1'b1;
      else if (do_write)
         next_w_full = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full       <= 1'b0;
         s_axi_awready <= 1'b0;
      end
      else
      begin
         aw_full       <= next_aw_full;
         s_axi_awready <= ~next_aw_full;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_full       <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         w_full       <= next_w_full;
         s_axi_wready <= ~next_w_full;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         aw_addr <= '0;
      else if (s_axi_awvalid && s_axi_awready)
         aw_addr <= s_axi_awaddr;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_byte  <= 8'h00;
         w_lane0 <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_byte  <= s_axi_wdata[7:0];
         w_lane0 <= s_axi_wstrb[0];
      end
   end

   // ************************************************************
   // Write decode and response
   // ************************************************************
   assign wr_idx    = aw_addr[5:2];
   assign wr_hit_a  = (aw_addr[ADDR_W-1:6] == OFS_CFG_A_BASE[ADDR_W-1:6]) && (aw_addr[1:0] == 2'h0);
   assign wr_hit_b  = (aw_addr[ADDR_W-1:6] == OFS_CFG_B_BASE[ADDR_W-1:6]) && (aw_addr[1:0] == 2'h0);
   assign wr_hit_st = (aw_addr == OFS_STATUS);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_hit_a || wr_hit_b || wr_hit_st) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ************************************************************
   // Per-channel configuration registers
   // ************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            cfg_a[i] <= CFG_A_RESET;
            cfg_b[i] <= CFG_B_RESET;
         end
      end
      else if (do_write && w_lane0)
      begin
         if (wr_hit_a)
            cfg_a[wr_idx] <= w_byte;
         if (wr_hit_b)
            cfg_b[wr_idx] <= w_byte;
      end
   end

   // ************************************************************
   // Read channel
   // ************************************************************
   // Only one read is in flight: the address is refused until the data
   // has been taken, which keeps the read path a single register.
   assign ar_take = s_axi_arvalid & s_axi_arready;

   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b0;
      if (s_axi_araddr[1:0] == 2'h0)
      begin
         if (s_axi_araddr[ADDR_W-1:6] == OFS_CFG_A_BASE[ADDR_W-1:6])
         begin
            rd_word = {24'h00_0000, cfg_a[s_axi_araddr[5:2]]};
            rd_hit  = 1'b1;
         end
         else if (s_axi_araddr[ADDR_W-1:6] == OFS_CFG_B_BASE[ADDR_W-1:6])
         begin
            rd_word = {24'h00_0000, cfg_b[s_axi_araddr[5:2]]};
            rd_hit  = 1'b1;
         end
         else if (s_axi_araddr == OFS_STATUS)
         begin
            rd_word = {16'h0000, rx_clock_rate_ok};
            rd_hit  = 1'b1;
         end
      end
   end

   always_comb
   begin
      next_rvalid = s_axi_rvalid;
      if (ar_take)
         next_rvalid = 1'b1;
      else if (s_axi_rready)
         next_rvalid = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b0;
      end
      else
      begin
         s_axi_rvalid  <= next_rvalid;
         s_axi_arready <= ~next_rvalid & ~ar_take;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (ar_take)
      begin
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // ************************************************************
   // Channels
   // ************************************************************
   for (genvar ch = 0; ch < NUM_CH; ch++)
   begin : g_ch
      logic       mon_prev;
      logic [3:0] mon_cnt;
      logic [3:0] period;
      logic [3:0] lo_cyc;
      logic [3:0] hi_cyc;

      assign ch_cfg[ch].fmt          = lrso_fmt_t'(cfg_b[ch][B_FMT_LSB +: 2]);
      assign ch_cfg[ch].data_pol     = cfg_b[ch][B_DATA_POL];
      assign ch_cfg[ch].edge_fall    = cfg_b[ch][B_CLK_EDGE];
      assign ch_cfg[ch].ind_sel      = lrso_ind_t'(cfg_b[ch][B_IND_LSB +: 3]);
      assign ch_cfg[ch].powerdown    = cfg_a[ch][A_RX_POWERDOWN];
      assign ch_cfg[ch].pd_tristate  = cfg_a[ch][A_PD_TRISTATE];
      assign ch_cfg[ch].single_ended = cfg_a[ch][A_SINGLE_ENDED];

      lrso_chan u_chan (
         .aclk    (aclk),
         .aresetn (aresetn),
         .cfg     (ch_cfg[ch]),
         .line    (line_in[ch]),
         .pins    (rx_pins[ch])
      );

      // The recovered clock is checked against the nominal line rate by
      // counting system cycles between its rising edges. At a 10 MHz
      // system clock the check is coarse: it only tells T1 from E1 rate
      // and a stopped clock, not ppm offsets.
      assign lo_cyc = cfg_a[ch][A_E1_MODE] ? 4'(E1_MIN_CYC) : 4'(T1_MIN_CYC);
      assign hi_cyc = cfg_a[ch][A_E1_MODE] ? 4'(E1_MAX_CYC) : 4'(T1_MAX_CYC);
      assign period = mon_cnt + 4'h1;

      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            mon_prev <= 1'b0;
         else
            mon_prev <= line_in[ch].rclk;
      end

      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            mon_cnt              <= 4'h0;
            rx_clock_rate_ok[ch] <= 1'b0;
         end
         else if (line_in[ch].rclk && !mon_prev)
         begin
            mon_cnt              <= 4'h0;
            rx_clock_rate_ok[ch] <= (period >= lo_cyc) && (period <= hi_cyc);
         end
         else
         begin
            if (mon_cnt != 4'hF)
               mon_cnt <= period;
            if (period > hi_cyc)
               rx_clock_rate_ok[ch] <= 1'b0;
         end
      end
   end

endmodule // lrso_top

// ===== inc/lrso_pkg.sv
// Package of constants and types for the receive system-side output formatter.
package lrso_pkg;

   // ************************************************************
   // Bus and register map
   // ************************************************************
   localparam int          NUM_CH          = 16;
   localparam int          ADDR_W          = 12;
   localparam logic [11:0] OFS_CFG_A_BASE  = 12'h0_000;
   localparam logic [11:0] OFS_CFG_B_BASE  = 12'h0_040;
   localparam logic [11:0] OFS_STATUS      = 12'h0_080;
   localparam logic [7:0]  CFG_A_RESET     = 8'h00;
   localparam logic [7:0]  CFG_B_RESET     = 8'h00;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int A_E1_MODE      = 0;
   localparam int A_SINGLE_ENDED = 1;
   localparam int A_RX_POWERDOWN = 5;
   localparam int A_PD_TRISTATE  = 6;
   localparam int B_FMT_LSB      = 0;
   localparam int B_DATA_POL     = 3;
   localparam int B_CLK_EDGE     = 4;
   localparam int B_IND_LSB      = 5;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int T1_RATE_KHZ   = 1544;
   localparam int E1_RATE_KHZ   = 2048;
   // A whole recovered period spans either the floor or one more cycle.
   localparam int T1_MIN_CYC = 1_000_000 / (T1_RATE_KHZ * CLK_PERIOD_NS);
   localparam int T1_MAX_CYC = T1_MIN_CYC + 1;
   localparam int E1_MIN_CYC = 1_000_000 / (E1_RATE_KHZ * CLK_PERIOD_NS);
   localparam int E1_MAX_CYC = E1_MIN_CYC + 1;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      LRSO_FMT_SINGLE_NRZ = 2'h0,
      LRSO_FMT_DUAL_NRZ   = 2'h1,
      LRSO_FMT_DUAL_RZ    = 2'h2,
      LRSO_FMT_SLICED     = 2'h3
   } lrso_fmt_t;

   typedef enum logic [2:0] {
      LRSO_IND_PATT_SYNC = 3'h0,
      LRSO_IND_AIS       = 3'h1,
      LRSO_IND_EXZ       = 3'h2,
      LRSO_IND_BPV       = 3'h3,
      LRSO_IND_EXZ_BPV   = 3'h4,
      LRSO_IND_LOS       = 3'h5,
      LRSO_IND_RCLK      = 3'h6,
      LRSO_IND_RAIL_XOR  = 3'h7
   } lrso_ind_t;

   typedef struct packed {
      lrso_fmt_t fmt;
      logic      data_pol;
      logic      edge_fall;
      lrso_ind_t ind_sel;
      logic      powerdown;
      logic      pd_tristate;
      logic      single_ended;
   } lrso_cfg_t;

   typedef struct packed {
      logic tip_hi;
      logic tip_lo;
      logic ring_hi;
      logic ring_lo;
      logic rclk;
      logic dec_data;
      logic patt_sync;
      logic ais;
      logic exz;
      logic bpv;
      logic los;
   } lrso_line_t;

   typedef struct packed {
      logic d1;
      logic d1_oe;
      logic d2;
      logic d2_oe;
   } lrso_pins_t;

endpackage

// ===== verif/lrso_framer_model.sv
// Downstream framer model sampling channel 0 pins on the falling recovered edge.
`timescale 1ns/1ns
module lrso_framer_model
   import lrso_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic rclk,
   input  lrso_pins_t pins,
   output logic       d1,
   output logic       d2
);
   logic rclk_q;
   // Sampling half a period after the update edge leaves the pins time to settle.
   // A released pin reads as the inverse of the last sample, never as a stale match.
   always_ff @(posedge aclk)
   begin
      rclk_q <= rclk;
      if (!aresetn)
      begin
         d1 <= 1'b0;
         d2 <= 1'b0;
      end
      else if (rclk_q && !rclk)
      begin
         d1 <= pins.d1_oe ? pins.d1 : ~d1;
         d2 <= pins.d2_oe ? pins.d2 : ~d2;
      end
   end
endmodule // lrso_framer_model

// ===== verif/lrso_properties.sv
// Port checker for the receive output formatter, bound to its top.
`timescale 1ns/1ns
module lrso_top_properties
   import lrso_pkg::*;
(
   input wire logic               aclk,
   input wire logic               aresetn,
   input wire logic               s_axi_awvalid,
   input wire logic               s_axi_awready,
   input wire logic               s_axi_wvalid,
   input wire logic               s_axi_wready,
   input wire logic [1:0]         s_axi_bresp,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic [31:0]        s_axi_rdata,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready,
   input lrso_line_t [NUM_CH-1:0] line_in,
   input lrso_pins_t [NUM_CH-1:0] rx_pins,
   input wire logic [NUM_CH-1:0]  rx_clock_rate_ok
);
   logic [4:0] since_rise;
   logic       rclk_q;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk)
   begin
      rclk_q <= line_in[0].rclk;
      if (!aresetn || (line_in[0].rclk && !rclk_q))
         since_rise <= 5'h0;
      else if (since_rise != 5'h1f)
         since_rise <= since_rise + 5'h1;
   end
   sequence s_write_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_read_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_reset_pins_idle: assert property (disable iff (1'b0)
      !aresetn |=> rx_pins == '0 && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs not idle after reset");
   a_oe_pair_same: assert property (rx_pins[0].d1_oe == rx_pins[0].d2_oe)
      else $error("pin enables differ");
   a_undriven_low: assert property (!rx_pins[0].d1_oe |-> !rx_pins[0].d1 && !rx_pins[0].d2)
      else $error("released pin shows data");
   a_rate_drop: assert property (since_rise > 5'd12 |-> !rx_clock_rate_ok[0])
      else $error("rate flag kept without clock");
   a_rate_rise: assert property ($rose(rx_clock_rate_ok[0]) |-> since_rise <= 5'd3)
      else $error("rate flag rose away from clock edge");
   a_write_answer: assert property (s_write_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property (s_read_taken |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule // lrso_top_properties
bind lrso_top lrso_top_properties u_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .line_in(line_in), .rx_pins(rx_pins), .rx_clock_rate_ok(rx_clock_rate_ok));

// ===== verif/test_lineif_rx_system_output.sv
// Self-checking bench for the receive system-side output formatter.
`timescale 1ns/1ns
module test_lineif_rx_system_output
   import lrso_pkg::*;
;
   logic                    aclk = 1'b0;
   logic                    aresetn = 1'b0;
   logic [ADDR_W-1:0]       awaddr = '0, araddr = '0;
   logic [31:0]             wdata = '0, rdata, data;
   logic                    awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic                    awready, wready, bvalid, arready, rvalid, fr_d1, fr_d2;
   logic [1:0]              bresp, rresp, resp;
   lrso_line_t              ln = '0;
   lrso_line_t [NUM_CH-1:0] line_in;
   lrso_pins_t [NUM_CH-1:0] rx_pins;
   logic [NUM_CH-1:0]       rate_ok;
   logic                    run = 1'b1;
   logic [4:0]              hot [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h04, 5'h01};
   int                      mismatches = 0, num_checks = 0, ph = 0;
   always #50 aclk = ~aclk;
   always_comb
   begin
      line_in = '0;
      line_in[0] = ln;
   end
   // Recovered clock of six system cycles, inside the T1 window.
   always @(posedge aclk)
   begin
      ph <= (ph == 2) ? 0 : ph + 1;
      if (run && ph == 2)
         ln.rclk <= ~ln.rclk;
   end
   lrso_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .line_in(line_in),
      .rx_pins(rx_pins), .rx_clock_rate_ok(rate_ok));
   lrso_framer_model fr_u (.aclk(aclk), .aresetn(aresetn), .rclk(ln.rclk), .pins(rx_pins[0]),
      .d1(fr_d1), .d2(fr_d2));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(bvalid && bready))
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!(rvalid && rready))
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end
      resp = rresp;
      data = rdata;
      rready <= 1'b0;
   endtask
   task automatic settle();
      repeat (16) @(posedge aclk);
   endtask
   task automatic t_regs();
      rd(OFS_CFG_A_BASE);
      check("cfg_a reset", data, {24'h0, CFG_A_RESET});
      rd(OFS_CFG_B_BASE);
      check("cfg_b reset", data, {24'h0, CFG_B_RESET});
      rd(12'h100);
      check("unmapped read", {resp, data[29:0]}, {RESP_SLVERR, 30'h0});
      wr(12'h100, 32'h0000_0001);
      check("unmapped write", 32'(resp), 32'(RESP_SLVERR));
      wr(OFS_CFG_B_BASE + 12'h4, 32'hffff_ffff);
      rd(OFS_CFG_B_BASE + 12'h4);
      check("cfg_b upper bits", data, 32'h0000_00ff);
   endtask
   task automatic t_single();
      int cnt;
      ln.dec_data <= 1'b1;
      settle();
      check("single data", 32'(fr_d1), 32'h1);
      wr(OFS_CFG_B_BASE, 32'h0000_0008);
      settle();
      check("single data inverted", 32'(fr_d1), 32'h0);
      for (int k = 0; k < 6; k++)
      begin
         wr(OFS_CFG_B_BASE, 32'(k * 32 + 8));
         ln[4:0] <= hot[k];
         settle();
         check("indication on", 32'(fr_d2), 32'h1);
         ln[4:0] <= 5'h0;
         settle();
         check("indication off", 32'(fr_d2), 32'h0);
      end
      wr(OFS_CFG_B_BASE, 32'h0000_00c0);
      cnt = 0;
      repeat (24) @(posedge aclk) cnt += rx_pins[0].d2;
      check("indication clock", cnt, 32'd12);
   endtask
   task automatic t_rails(input logic [3:0] tips, input logic [1:0] exp);
      ln[10:7] <= tips;
      settle();
      check("rails", 32'({fr_d1, fr_d2}), 32'(exp));
   endtask
   task automatic t_dual();
      int cnt;
      ln.dec_data <= 1'b0;
      wr(OFS_CFG_B_BASE, 32'h0000_0001);
      t_rails(4'h9, 2'h2);
      t_rails(4'h6, 2'h1);
      t_rails(4'h4, 2'h0);
      wr(OFS_CFG_A_BASE, 32'h0000_0002);
      t_rails(4'h4, 2'h1);
      wr(OFS_CFG_B_BASE, 32'h0000_0019);
      t_rails(4'h4, 2'h2);
      wr(OFS_CFG_B_BASE, 32'h0000_00e0);
      settle();
      check("indication xor", 32'(fr_d2), 32'h1);
      wr(OFS_CFG_B_BASE, 32'h0000_0002);
      settle();
      cnt = 0;
      repeat (24) @(posedge aclk) cnt += rx_pins[0].d2;
      check("rz pulses", 32'(cnt >= 8 && cnt <= 16), 32'h1);
      wr(OFS_CFG_B_BASE, 32'h0000_0003);
      ln[10:7] <= 4'h8;
      repeat (3) @(posedge aclk);
      check("sliced pass", 32'(rx_pins[0].d1), 32'h1);
   endtask
   task automatic t_power();
      wr(OFS_CFG_A_BASE, 32'h0000_0062);
      settle();
      check("powerdown release", 32'(rx_pins[0]), 32'h0);
      wr(OFS_CFG_A_BASE, 32'h0000_0022);
      settle();
      check("powerdown low", 32'(rx_pins[0]), 32'h5);
   endtask
   task automatic t_rate();
      wr(OFS_CFG_A_BASE, 32'h0000_0000);
      settle();
      rd(OFS_STATUS);
      check("t1 rate", data, 32'h0000_0001);
      wr(OFS_CFG_A_BASE, 32'h0000_0001);
      settle();
      rd(OFS_STATUS);
      check("e1 rate", data, 32'h0000_0000);
      wr(OFS_CFG_A_BASE, 32'h0000_0000);
      run <= 1'b0;
      settle();
      rd(OFS_STATUS);
      check("stopped clock", data, 32'h0000_0000);
      run <= 1'b1;
   endtask
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_single();
      t_dual();
      t_power();
      t_rate();
      conclude();
   end
   initial
   begin
      #2_000_000;
      mismatches++;
      conclude();
   end
endmodule // test_lineif_rx_system_output
